/* logic/asc_fifo.sv */
// result FIFO between the conversion core and the serial sequencer
// assumes a single clock; storage is flip-flops
`timescale 1ns/1ps
module asc_fifo #(
   parameter int unsigned W = 22,
   parameter int unsigned DEPTH = 16
) (
   input wire logic REF_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } asc_fifo_s;
   asc_fifo_s st_reg;
   asc_fifo_s st_next;
   logic full;
   logic empty;

   // extra pointer bit tells full from empty
   assign empty = (st_reg.wp == st_reg.rp);
   assign full = (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]) && (st_reg.wp[AW] != st_reg.rp[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = st_reg.mem[st_reg.rp[AW-1:0]];

   always_comb
   begin
      st_next = st_reg;
      if (in_valid && !full)
      begin
         st_next.mem[st_reg.wp[AW-1:0]] = in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (out_ready && !empty)
         st_next.rp = st_reg.rp + 1'b1;
   end

   always_ff @(posedge REF_CLK_IN)
   begin
      if (SYS_RST_IN)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   property p_no_write_when_full;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      full && in_valid |=> st_reg.wp == $past(st_reg.wp);
   endproperty
   a_no_write_when_full: assert property (p_no_write_when_full)
      else $error("fifo pointer moved while full");
endmodule : asc_fifo

/* logic/asc_serial_ctrl.sv */
// serial interface and conversion-state sequencer of a delta-sigma converter
// assumes the conversion core pushes signed results into RESULT_*; pins are asynchronous
// Functional notes
// - external conversion clock: conversion lasts 10278 of its periods.
// - single-notch internal oscillator: convert 67 ms when select low, 80 ms high.
// - dual-notch internal oscillator with select low: convert 73 ms.
// - after conversion, sleep while chip select stays high.
// - internal serial clock: data output bounded by 24 clocks.
// - external serial clock: data output ends after 24 clocks at most.
// - serial data advances to the next bit on each serial clock fall.
// - internal mode drives serial clock at conversion clock over 8.
// - external mode takes the serial clock pin as input.
// - clock mode chosen at power-up and at every chip select fall.
// - serial clock high or floating picks internal, low picks external.
// - data output shows the latest result, most significant bit first; the code shows the oldest result held in the buffer.
// - chip select high puts serial data in high impedance.
// - chip select low in convert or sleep shows the done flag.
// - chip select rise after the first serial clock rise in data output aborts and starts conversion.
// - chip select held low gives continuous conversion at full rate.
// - external two-wire mode is controlled by serial clock alone.
// - internal two-wire converts continuously; single cycle follows chip select fall.
// - frame is done flag, dummy zero, sign, then 21 result bits.
// - after the 24th serial clock fall (24th rise with internal serial clock), data goes high and conversion starts.
// - weak pull-up on serial clock is enabled around chip select fall.
`timescale 1ns/1ps
module asc_serial_ctrl #(
   parameter int unsigned CONV_LOW_CYC = asc_pkg::CONV_LOW_MS * asc_pkg::CYC_PER_MS,
   parameter int unsigned CONV_HIGH_CYC = asc_pkg::CONV_HIGH_MS * asc_pkg::CYC_PER_MS,
   parameter int unsigned CONV_DUAL_CYC = asc_pkg::CONV_DUAL_MS * asc_pkg::CYC_PER_MS,
   parameter int unsigned EXT_DET_CYC = asc_pkg::EXT_DET_CYC
) (
   input wire logic REF_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic DUAL_NOTCH_IN,
   input wire logic REJECTION_SELECT_IN,
   input wire logic CS_N_IN,
   input wire logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE_OUT,
   output logic SCK_PULLUP_EN_OUT,
   output logic SDO_OUT,
   output logic SDO_OE_OUT,
   input wire logic [asc_pkg::RESULT_W-1:0] RESULT_IN,
   input wire logic RESULT_VALID_IN,
   output logic RESULT_READY_OUT,
   output logic CONV_START_OUT,
   output logic INT_SCK_MODE_OUT,
   output logic EXT_CONV_CLK_OUT
);
   typedef struct packed
   {
      asc_pkg::asc_state_e st;
      logic [23:0] cnt;
      logic [15:0] det;
      logic [4:0] bitcnt;
      logic [23:0] shreg;
      logic started;
      logic int_mode;
      logic [1:0] powerup;
      logic sck_o;
      logic sdo;
      logic sdo_oe;
      logic start_p;
      logic cs_prev;
      logic sck_prev;
      logic rej_prev;
   } asc_ctrl_s;
   asc_ctrl_s st_reg;
   asc_ctrl_s st_next;

   logic [2:0] pins_s;
   logic cs_s;
   logic sck_s;
   logic rej_s;
   logic fifo_valid;
   logic fifo_ready;
   logic [asc_pkg::RESULT_W-1:0] fifo_data;
   logic ext_osc;
   logic tick;
   logic rej_rise;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic [23:0] conv_lim;
   logic [23:0] half_lim;
   logic [23:0] test_lim;

   // pins cross into the clock domain; idle levels are chip select high, clock high, select low
   asc_sync #(.W(3), .INIT(3'h6)) u_sync (
      .REF_CLK_IN(REF_CLK_IN),
      .SYS_RST_IN(SYS_RST_IN),
      .async_in({CS_N_IN, SCK_IN, REJECTION_SELECT_IN}),
      .sync_out(pins_s)
   );
   assign cs_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign rej_s = pins_s[0];

   // results wait here; a full buffer stalls the core through its ready
   asc_fifo #(.W(asc_pkg::RESULT_W), .DEPTH(asc_pkg::FIFO_DEPTH)) u_fifo (
      .REF_CLK_IN(REF_CLK_IN),
      .SYS_RST_IN(SYS_RST_IN),
      .in_data(RESULT_IN),
      .in_valid(RESULT_VALID_IN),
      .in_ready(RESULT_READY_OUT),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready)
   );

   // edge detectors read only the second synchroniser stage
   assign cs_fall = st_reg.cs_prev && !cs_s;
   assign cs_rise = !st_reg.cs_prev && cs_s;
   assign sck_rise = !st_reg.sck_prev && sck_s;
   assign sck_fall = st_reg.sck_prev && !sck_s;
   assign rej_rise = !st_reg.rej_prev && rej_s;
   assign ext_osc = (st_reg.det != 16'h0000);

   // one tick per cycle on the internal oscillator, one per external clock period otherwise
   assign tick = ext_osc ? rej_rise : 1'b1;

   // state lengths chosen by oscillator source, variant and rejection level
   always_comb
   begin
      if (ext_osc)
      begin
         conv_lim = asc_pkg::CONV_EXT_PERIODS;
         half_lim = asc_pkg::HALF_EXT_TICKS;
         test_lim = asc_pkg::DONE_TEST_EXT_TICKS;
      end
      else if (DUAL_NOTCH_IN)
      begin
         // a high select is outside the dual part's use; it falls back to the long setting
         conv_lim = rej_s ? 24'(CONV_HIGH_CYC) : 24'(CONV_DUAL_CYC);
         half_lim = 24'(asc_pkg::HALF_DUAL_CYC);
         test_lim = 24'(asc_pkg::DONE_TEST_DUAL_CYC);
      end
      else
      begin
         conv_lim = rej_s ? 24'(CONV_HIGH_CYC) : 24'(CONV_LOW_CYC);
         half_lim = 24'(asc_pkg::HALF_SINGLE_CYC);
         test_lim = 24'(asc_pkg::DONE_TEST_SINGLE_CYC);
      end
   end

   // result leaves the buffer only when a conversion ends
   assign fifo_ready = (st_reg.st == asc_pkg::ASC_CONVERT) && (st_reg.cnt >= conv_lim);

   // sequencer
   always_comb
   begin
      st_next = st_reg;
      st_next.start_p = 1'b0;
      st_next.cs_prev = cs_s;
      st_next.sck_prev = sck_s;
      st_next.rej_prev = rej_s;
      // external conversion clock detection window restarts on each rising edge
      if (rej_rise)
         st_next.det = 16'(EXT_DET_CYC);
      else if (st_reg.det != 16'h0000)
         st_next.det = st_reg.det - 16'h0001;
      // power-up capture waits until the synchroniser holds the real pin level, then every chip select fall
      if (st_reg.powerup != 2'h0)
         st_next.powerup = st_reg.powerup - 2'h1;
      if (st_reg.powerup == 2'h1 || cs_fall)
         st_next.int_mode = sck_s;
      unique case (st_reg.st)
         asc_pkg::ASC_CONVERT:
         begin
            if (tick && st_reg.cnt < conv_lim)
               st_next.cnt = st_reg.cnt + 24'h000001;
            // with no result ready the conversion holds until one arrives
            if (fifo_ready && fifo_valid)
            begin
               st_next.shreg = {1'b0, 1'b0, fifo_data};
               st_next.cnt = '0;
               st_next.st = asc_pkg::ASC_SLEEP;
            end
         end
         asc_pkg::ASC_SLEEP:
         begin
            st_next.cnt = '0;
            st_next.started = 1'b0;
            // chip select low leaves sleep, so holding it low converts back to back
            if (!cs_s && !cs_fall)
            begin
               if (st_reg.int_mode)
               begin
                  st_next.sck_o = 1'b0;
                  st_next.st = asc_pkg::ASC_DONE_TEST;
               end
               else
                  st_next.st = asc_pkg::ASC_DATA_OUT;
            end
         end
         asc_pkg::ASC_DONE_TEST:
         begin
            if (cs_s)
               st_next.st = asc_pkg::ASC_SLEEP;
            else if (tick)
            begin
               st_next.cnt = st_reg.cnt + 24'h000001;
               if (st_reg.cnt + 24'h000001 >= test_lim)
               begin
                  // first rising edge enters the data output state
                  st_next.cnt = '0;
                  st_next.sck_o = 1'b1;
                  st_next.started = 1'b1;
                  st_next.st = asc_pkg::ASC_DATA_OUT;
               end
            end
         end
         asc_pkg::ASC_DATA_OUT:
         begin
            if (cs_rise)
            begin
               // abort only counts once the first rising edge was seen
               if (st_reg.started)
               begin
                  st_next.st = asc_pkg::ASC_CONVERT;
                  st_next.start_p = 1'b1;
                  st_next.bitcnt = '0;
                  st_next.sck_o = 1'b1;
                  // the serial clock count may stand mid half period; the conversion must start from zero
                  st_next.cnt = '0;
               end
               else
                  st_next.st = asc_pkg::ASC_SLEEP;
            end
            else if (st_reg.int_mode)
            begin
               // internal serial clock: conversion clock over 8 with an external clock, half_lim cycles per half period on the oscillator
               if (tick)
                  st_next.cnt = st_reg.cnt + 24'h000001;
               if (tick && st_reg.cnt + 24'h000001 >= half_lim)
               begin
                  st_next.cnt = '0;
                  if (st_reg.sck_o)
                  begin
                     st_next.sck_o = 1'b0;
                     st_next.shreg = {st_reg.shreg[22:0], 1'b1};
                     st_next.bitcnt = st_reg.bitcnt + 5'h01;
                  end
                  else if (st_reg.bitcnt == asc_pkg::LAST_BIT)
                  begin
                     // 24th rise ends the frame; clock stays high
                     st_next.sck_o = 1'b1;
                     st_next.bitcnt = '0;
                     st_next.st = asc_pkg::ASC_CONVERT;
                     st_next.start_p = 1'b1;
                  end
                  else
                     st_next.sck_o = 1'b1;
               end
            end
            else
            begin
               if (sck_rise)
                  st_next.started = 1'b1;
               if (sck_fall && st_reg.started)
               begin
                  if (st_reg.bitcnt == asc_pkg::LAST_BIT)
                  begin
                     st_next.bitcnt = '0;
                     st_next.st = asc_pkg::ASC_CONVERT;
                     st_next.start_p = 1'b1;
                  end
                  else
                  begin
                     st_next.shreg = {st_reg.shreg[22:0], 1'b1};
                     st_next.bitcnt = st_reg.bitcnt + 5'h01;
                  end
               end
            end
         end
      endcase
      // serial data: done flag outside data output, frame bit inside
      unique case (st_next.st)
         asc_pkg::ASC_CONVERT: st_next.sdo = 1'b1;
         asc_pkg::ASC_SLEEP: st_next.sdo = 1'b0;
         asc_pkg::ASC_DONE_TEST: st_next.sdo = 1'b0;
         asc_pkg::ASC_DATA_OUT: st_next.sdo = st_next.shreg[23];
      endcase
      st_next.sdo_oe = !cs_s;
   end

   always_ff @(posedge REF_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         st_reg <= '0;
         st_reg.st <= asc_pkg::ASC_CONVERT;
         st_reg.int_mode <= 1'b1;
         st_reg.powerup <= 2'h3;
         st_reg.sck_o <= 1'b1;
         st_reg.sdo <= 1'b1;
         st_reg.cs_prev <= 1'b1;
         st_reg.sck_prev <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // pin drivers
   assign SCK_OUT = st_reg.sck_o;
   assign SCK_OE_OUT = st_reg.int_mode && st_reg.sdo_oe;
   assign SCK_PULLUP_EN_OUT = !st_reg.sdo_oe;
   assign SDO_OUT = st_reg.sdo;
   assign SDO_OE_OUT = st_reg.sdo_oe;
   assign CONV_START_OUT = st_reg.start_p;
   assign INT_SCK_MODE_OUT = st_reg.int_mode;
   assign EXT_CONV_CLK_OUT = ext_osc;

   property p_sdo_hiz;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      cs_s |=> !SDO_OE_OUT;
   endproperty
   a_sdo_hiz: assert property (p_sdo_hiz)
      else $error("serial data driven with chip select high");

   property p_busy_flag;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (st_reg.st == asc_pkg::ASC_CONVERT) |-> SDO_OUT;
   endproperty
   a_busy_flag: assert property (p_busy_flag)
      else $error("done flag low during conversion");

   property p_sleep_hold;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (st_reg.st == asc_pkg::ASC_SLEEP) && cs_s ##1 cs_s |-> (st_reg.st == asc_pkg::ASC_SLEEP) && !SDO_OUT;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("left sleep with chip select high");

   property p_count_clear;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      $rose(st_reg.start_p) |-> (st_reg.bitcnt == 5'h00) && (st_reg.st == asc_pkg::ASC_CONVERT);
   endproperty
   a_count_clear: assert property (p_count_clear)
      else $error("bit count not cleared at conversion start");

   property p_abort;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (st_reg.st == asc_pkg::ASC_DATA_OUT) && st_reg.started && cs_rise |=> st_reg.start_p ##1 SDO_OUT;
   endproperty
   a_abort: assert property (p_abort)
      else $error("chip select rise did not abort");

   property p_mode_select;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      cs_fall |=> (INT_SCK_MODE_OUT == $past(sck_s));
   endproperty
   a_mode_select: assert property (p_mode_select)
      else $error("clock mode not taken from serial clock level");

   property p_last_fall;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (st_reg.st == asc_pkg::ASC_DATA_OUT) && !st_reg.int_mode && st_reg.started && sck_fall
         && (st_reg.bitcnt == asc_pkg::LAST_BIT) && !cs_rise |=> (st_reg.st == asc_pkg::ASC_CONVERT) && SDO_OUT;
   endproperty
   a_last_fall: assert property (p_last_fall)
      else $error("24th fall did not start a conversion");

   property p_shift;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      (st_reg.st == asc_pkg::ASC_DATA_OUT) && !st_reg.int_mode && st_reg.started && sck_fall
         && (st_reg.bitcnt < asc_pkg::LAST_BIT) && !cs_rise |=> (st_reg.shreg[23:1] == $past(st_reg.shreg[22:0]));
   endproperty
   a_shift: assert property (p_shift)
      else $error("serial data did not advance on falling edge");

   property p_frame_len;
      @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      st_reg.bitcnt <= asc_pkg::LAST_BIT;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame longer than 24 bits");
endmodule : asc_serial_ctrl

/* logic/asc_sync.sv */
// two flip-flop synchroniser for asynchronous pins
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
module asc_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic REF_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } asc_sync_s;
   asc_sync_s st_reg;
   asc_sync_s st_next;

   // first stage feeds only the second stage
   always_comb
   begin
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge REF_CLK_IN)
   begin
      if (SYS_RST_IN)
         st_reg <= {INIT, INIT};
      else
         st_reg <= st_next;
   end

   assign sync_out = st_reg.s2;
endmodule : asc_sync

/* shared/asc_pkg.sv */
// constants of the converter serial interface and conversion sequencer
// assumes a 100 MHz system clock; every slower rate is derived from it
package asc_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
   // convert state lengths on the internal oscillator, in ms
   localparam int unsigned CONV_LOW_MS = 67;
   localparam int unsigned CONV_HIGH_MS = 80;
   localparam int unsigned CONV_DUAL_MS = 73;
   // conversion length in external conversion clock periods
   localparam logic [23:0] CONV_EXT_PERIODS = 24'h002826;
   // longest data output state, internal oscillator, in us
   localparam int unsigned DOUT_MAX_US_SINGLE = 1250;
   localparam int unsigned DOUT_MAX_US_DUAL = 1400;
   localparam int unsigned FRAME_BITS = 24;
   // internal serial clock half period, rounded down so the frame never overruns
   localparam int unsigned HALF_SINGLE_CYC = DOUT_MAX_US_SINGLE * CLK_MHZ / (FRAME_BITS * 2);
   localparam int unsigned HALF_DUAL_CYC = DOUT_MAX_US_DUAL * CLK_MHZ / (FRAME_BITS * 2);
   // serial clock is the conversion clock divided by 8: half period is 4 ticks
   localparam logic [23:0] HALF_EXT_TICKS = 24'h000004;
   // delay from done-test to first serial clock rise, in us and in cycles
   localparam int unsigned DONE_TEST_US_SINGLE = 23;
   localparam int unsigned DONE_TEST_US_DUAL = 26;
   localparam int unsigned DONE_TEST_SINGLE_CYC = DONE_TEST_US_SINGLE * CLK_MHZ;
   localparam int unsigned DONE_TEST_DUAL_CYC = DONE_TEST_US_DUAL * CLK_MHZ;
   localparam logic [23:0] DONE_TEST_EXT_TICKS = 24'h000004;
   // an external conversion clock is seen if edges come at 5 kHz or faster
   localparam int unsigned EXT_DET_US = 200;
   localparam int unsigned EXT_DET_CYC = EXT_DET_US * CLK_MHZ;
   // frame layout
   localparam int unsigned RESULT_W = 22;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam int unsigned FIFO_DEPTH = 16;
   typedef enum logic [1:0] {ASC_CONVERT, ASC_SLEEP, ASC_DONE_TEST, ASC_DATA_OUT} asc_state_e;
endpackage : asc_pkg

/* testbench/asc_spi_master.sv */
// behavioural serial master that reads 24-bit result frames from the converter
// assumes the bench resolves the pins and calls these tasks just after a falling clock edge
`timescale 1ns/1ps
module asc_spi_master (
   input wire logic clk_in,
   input wire logic sdo_pin_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic sck_oe_out
);
   // idle: deselected, clock pin released to the pull-up
   initial
   begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      sck_oe_out = 1'b0;
   end
   // the mode level is set well ahead of the chip select fall
   task automatic select(input logic ext);
      sck_oe_out = ext;
      sck_out = 1'b0;
      repeat (4) @(negedge clk_in);
      cs_n_out = 1'b0;
      repeat (5) @(negedge clk_in);
   endtask : select
   // each level held six cycles because the pins are synchronised inside
   task automatic clock_bits(input int n, output logic [23:0] data);
      data = '1;
      for (int i = 0; i < n; i++)
      begin
         sck_out = 1'b1;
         data = {data[22:0], sdo_pin_in};
         repeat (6) @(negedge clk_in);
         sck_out = 1'b0;
         repeat (6) @(negedge clk_in);
      end
   endtask : clock_bits
   // release chip select and the clock pin
   task automatic deselect;
      cs_n_out = 1'b1;
      sck_oe_out = 1'b0;
      repeat (6) @(negedge clk_in);
   endtask : deselect
endmodule : asc_spi_master

/* testbench/testbench.sv */
// self-checking bench for the converter serial sequencer and its result buffer
// assumes the sequencer guards its internals with its own assertions; pins are resolved here
`timescale 1ns/1ps
module testbench;
   localparam int unsigned C_LOW = 200;
   localparam int unsigned C_HIGH = 240;
   localparam int unsigned C_DUAL = 220;
   logic clk, rst, dual, rej, res_valid;
   logic [21:0] x, px;
   logic [23:0] pd;
   int n_starts = 0;
   logic flt = 1'b0;
   logic [21:0] res;
   logic sck_o, sck_oe, pull_en, sdo, sdo_oe, res_ready, conv_start, int_mode, ext_clk;
   logic m_cs_n, m_sck, m_oe, sck_pin, sdo_pin;
   logic [15:0] rnd;
   logic [23:0] d;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int t_start, w, e;
   logic [21:0] exp_q[$];

   asc_serial_ctrl #(.CONV_LOW_CYC(C_LOW), .CONV_HIGH_CYC(C_HIGH), .CONV_DUAL_CYC(C_DUAL), .EXT_DET_CYC(100)) i_dut (
      .REF_CLK_IN(clk), .SYS_RST_IN(rst), .DUAL_NOTCH_IN(dual), .REJECTION_SELECT_IN(rej),
      .CS_N_IN(m_cs_n), .SCK_IN(sck_pin), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe), .SCK_PULLUP_EN_OUT(pull_en),
      .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .RESULT_IN(res), .RESULT_VALID_IN(res_valid),
      .RESULT_READY_OUT(res_ready), .CONV_START_OUT(conv_start), .INT_SCK_MODE_OUT(int_mode),
      .EXT_CONV_CLK_OUT(ext_clk));
   asc_spi_master i_master (.clk_in(clk), .sdo_pin_in(sdo_pin), .cs_n_out(m_cs_n), .sck_out(m_sck), .sck_oe_out(m_oe));

   // released pins wander every cycle, the clock pin only while its pull-up is off, so a stale level is never mistaken for data
   assign sck_pin = sck_oe ? sck_o : (m_oe ? m_sck : (pull_en ? 1'b1 : flt));
   assign sdo_pin = sdo_oe ? sdo : flt;

   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // cycle count, conversion start stamp and hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      flt <= ~flt;
      if (conv_start === 1'b1)
      begin
         t_start <= cyc;
         n_starts <= n_starts + 1;
      end
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         end_sim();
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // bounded wait for the done flag to fall on the data pin
   task automatic wait_low(input int lim);
      w = 0;
      while (sdo_pin !== 1'b0 && w < lim)
      begin
         @(negedge clk);
         w++;
      end
      check(w < lim, 1'b1);
   endtask : wait_low

   // internal clock frame: each bit is taken in the low phase just before a rise of the pin
   task automatic read_int(output logic [23:0] data, output int span);
      logic prev, last;
      int n;
      prev = 1'b0;
      last = 1'b0;
      n = 0;
      span = 0;
      data = '1;
      for (int c = 0; c < 3000 && n < 24; c++)
      begin
         @(negedge clk);
         if (sck_pin === 1'b1 && !prev)
         begin
            data = {data[22:0], last};
            n++;
            if (n == 1)
               span = cyc;
            else if (n == 24)
               span = cyc - span;
         end
         last = sdo_pin;
         prev = sck_pin;
      end
   endtask : read_int

   task automatic end_sim;
      $display("errors %0d, checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // main sequence
   initial
   begin
      rst = 1'b1;
      dual = 1'b0;
      rej = 1'b0;
      res_valid = 1'b0;
      res = '0;
      rnd = 16'hed7f;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check({sdo_oe, sck_oe, pull_en, int_mode, conv_start}, 5'b00110);
      repeat (3) @(negedge clk);
      // fill the buffer back to back until it refuses; corner words lead
      res_valid = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         rnd = lfsr(lfsr(rnd));
         res = (i == 0) ? 22'h3fffff : (i == 1) ? 22'h000000 : {rnd[5:0], rnd};
         check(res_ready, 1'b1);
         exp_q.push_back(res);
         @(negedge clk);
      end
      res = 22'h155555;
      check(res_ready, 1'b0);
      @(negedge clk);
      res_valid = 1'b0;
      // chip select stays low: conversions run back to back, timed per rejection setting
      i_master.select(1'b1);
      check({int_mode, sdo_pin}, 2'b01);
      wait_low(400);
      for (int k = 0; k < 3; k++)
      begin
         rej = (k == 1);
         dual = (k == 2);
         e = (k == 0) ? C_LOW : (k == 1) ? C_HIGH : C_DUAL;
         i_master.clock_bits(24, d);
         x = exp_q.pop_front();
         check(d, {2'b00, x});
         // the reader keeps a running mean of the two latest results for dual-notch rejection
         if (k > 0)
            check(({1'b0, d[21:0]} + {1'b0, pd[21:0]}) >> 1, ({1'b0, x} + {1'b0, px}) >> 1);
         pd = d;
         px = x;
         check(sdo_pin, 1'b1);
         wait_low(400);
         w = cyc - t_start;
         check(w >= e - 1 && w <= e + 8, 1'b1);
      end
      // abort after a random count of rises; the next full frame must start again at the top
      rnd = lfsr(rnd);
      e = n_starts;
      i_master.clock_bits(1 + rnd[3:0], d);
      void'(exp_q.pop_front());
      i_master.deselect();
      check({n_starts != e, sdo_oe, sck_oe}, 3'b100);
      repeat (300) @(negedge clk);
      check(pull_en, 1'b1);
      i_master.select(1'b1);
      check(sdo_pin, 1'b0);
      i_master.clock_bits(24, d);
      check(d, {2'b00, exp_q.pop_front()});
      i_master.deselect();
      // internal clock picked through the pull-up, left again before the first rise
      repeat (300) @(negedge clk);
      i_master.select(1'b0);
      check({int_mode, sck_oe, sck_o, sdo_pin}, 4'b1100);
      i_master.deselect();
      check({sck_oe, sdo_oe}, 2'b00);
      i_master.select(1'b1);
      check({int_mode, sdo_pin}, 2'b00);
      i_master.deselect();
      // a fast toggle on rejection select is taken as a conversion clock, then lost
      repeat (40)
      begin
         rej = ~rej;
         repeat (4) @(negedge clk);
      end
      check(ext_clk, 1'b1);
      // internal clock frame paced by the conversion clock; released clock pin picks internal mode
      fork
         repeat (440)
         begin
            rej = ~rej;
            repeat (4) @(negedge clk);
         end
         begin
            i_master.select(1'b0);
            read_int(d, w);
            check(d, {2'b00, exp_q.pop_front()});
            // rise 1 to rise 24: 23 serial periods of 8 conversion clock ticks, 8 cycles per tick
            check(w >= 1464 && w <= 1480, 1'b1);
            check({sdo_pin, sck_o, ext_clk}, 3'b111);
            i_master.deselect();
         end
      join
      repeat (250) @(negedge clk);
      check(ext_clk, 1'b0);
      end_sim();
   end
endmodule : testbench
